/* srf_consts.svh */
`ifndef SRF_CONSTS_SVH
`define SRF_CONSTS_SVH
// register byte offsets on the 12-bit lite address
`define SRF_A_CTRL 12'h000
`define SRF_A_STAT_CODE 12'h004
`define SRF_A_REPLY 12'h008
`define SRF_A_SLEN 12'h00c
`define SRF_A_STATUS 12'h010
`define SRF_A_TAG_NEW 12'h014
`define SRF_A_TAG_DONE 12'h018
`define SRF_A_MEM_LO 12'h400
`define SRF_A_MEM_HI 12'h7e4
// control fields
`define SRF_CTRL_TASK 2
`define SRF_CTRL_GO 3
// status fields
`define SRF_ST_BUSY 0
`define SRF_ST_REFUSED 1
`define SRF_ST_OVERLAP 2
`define SRF_ST_FULL 3
// unit layout
`define SRF_B_SEL 11'd10
`define SRF_B_STATUS 11'd11
`define SRF_B_SLEN_HI 11'd18
`define SRF_B_SLEN_LO 11'd19
`define SRF_B_RLEN_LO 11'd23
`define SRF_B_BLOCK 11'd24
`define SRF_B_CODE 11'd27
`define SRF_HDR_LEN 11'd24
`define SRF_REPLY_LEN 11'd4
`define SRF_SENSE_MAX 10'd1000
// reply codes
`define SRF_RC_DONE 8'h00
`define SRF_RC_BADFRAME 8'h02
`define SRF_RC_NOTSUP 8'h04
`define SRF_RC_FAILED 8'h05
`define SRF_RC_OK 8'h08
`define SRF_RC_BADLUN 8'h09
`define SRF_RC_OVERLAP 8'h0a
`define SRF_TAGS 4
`endif

/* srf_pkg.sv */
package srf_pkg;
  typedef enum logic [1:0] {
    SRF_NONE = 2'b00,
    SRF_REPLY = 2'b01,
    SRF_SENSE = 2'b10,
    SRF_RSVD = 2'b11
  } srf_sel_e;
  typedef enum logic {
    SRF_IDLE = 1'b0,
    SRF_SEND = 1'b1
  } srf_state_e;
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } srf_byte_s;
endpackage

/* srf_framer.sv */
`timescale 1ns/10ps
`include "srf_consts.svh"
// What the document asks of this block and its initiator
// RL1: no data: status byte holds final status, both lengths zero, no blocks
// RL2: initiator ignores both lengths when no data is signalled
// RL3: reply content: status byte and sense length are zero, no sense block
// RL4: initiator ignores status and sense length for reply content
// RL5: reply content: reply length is four and the reply block follows
// RL6: reply block sent for any nonzero code and for every task answer
// RL7: reply block is four bytes, bytes 0-2 reserved, byte 3 the code
// RL8: legal reply codes 00,02,04,05,08,09,0a; the rest are reserved
// RL9: codes 00,04,05,08,09 only answer task frames, never commands
// RL10: a reused outstanding tag is answered with reply code 0a
// RL11: sense content: final status sent, reply length zero, no reply block
// RL12: initiator ignores reply length for sense content
// RL13: sense length is nonzero, at most 1000, that many sense bytes follow
// RL14: odd sense lengths allowed; then pad count nonzero and pad follows (here only pad_byte_count_o is driven, no pad bytes are sent)
// RL15: sequences interleave and responses may return in any order
// RL16: one sequence may span any number of connections either side opens
// RL17: selector codes 00 none, 01 reply, 10 sense, 11 reserved
// RL18: initiator drops a frame whose selector is reserved
// RL19: layout: sel byte 10, status 11, lengths 16-23 msb first, blocks at 24
// RL20: reserved bytes and bits are sent as zero
module srf_framer (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [11:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [11:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output srf_pkg::srf_byte_s unit_o,
  output logic unit_valid_o,
  input wire logic unit_ready_i,
  output logic [1:0] pad_byte_count_o
);
  // all checks below run on the one clock and sleep through reset
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  function automatic logic rc_reserved(input logic [7:0] c);
    rc_reserved = !(c == `SRF_RC_DONE || c == `SRF_RC_BADFRAME ||
      c == `SRF_RC_NOTSUP || c == `SRF_RC_FAILED || c == `SRF_RC_OK ||
      c == `SRF_RC_BADLUN || c == `SRF_RC_OVERLAP); // [RL8]
  endfunction
  function automatic logic rc_task_only(input logic [7:0] c);
    rc_task_only = c == `SRF_RC_DONE || c == `SRF_RC_NOTSUP ||
      c == `SRF_RC_FAILED || c == `SRF_RC_OK || c == `SRF_RC_BADLUN;
  endfunction
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction
  srf_pkg::srf_state_e state;
  srf_pkg::srf_sel_e f_sel;
  logic [31:0] mem [0:249];
  logic [7:0] f_stat, f_code, r_stat, r_code;
  logic [9:0] f_slen, r_slen;
  logic f_task, refused, overlap, full, ovl_pend;
  logic [10:0] idx, o_idx;
  logic [3:0] tag_v;
  logic [15:0] tag [0:`SRF_TAGS-1];
  logic aw_held, w_held;
  logic [11:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  // write path: address and data latched independently, then applied
  wire wa_ok = wa <= `SRF_A_TAG_DONE ||
    (wa >= `SRF_A_MEM_LO && wa <= `SRF_A_MEM_HI);
  wire do_wr = aw_held && w_held && !s_axi_bvalid_o;
  wire wr_ctrl = do_wr && wa == `SRF_A_CTRL;
  wire wr_stat = do_wr && wa == `SRF_A_STATUS;
  wire wr_new = do_wr && wa == `SRF_A_TAG_NEW;
  wire wr_done = do_wr && wa == `SRF_A_TAG_DONE;
  wire wr_mem = do_wr && wa >= `SRF_A_MEM_LO && wa <= `SRF_A_MEM_HI;
  wire [7:0] wmi = 8'(wa[9:2] - 8'h00);
  wire go = wr_ctrl && wd[`SRF_CTRL_GO];
  wire [1:0] go_sel = wd[1:0];
  wire go_task = wd[`SRF_CTRL_TASK];
  // launch checks; a bad request is refused, never framed
  wire bad_sense = go_sel == srf_pkg::SRF_SENSE &&
    (r_slen == 10'h000 || r_slen > `SRF_SENSE_MAX); // [RL13]
  wire bad_reply = go_sel == srf_pkg::SRF_REPLY &&
    (rc_reserved(r_code) || (rc_task_only(r_code) && !go_task)); // [RL9]
  wire bad_mix = (go_task || r_code != 8'h00) &&
    go_sel != srf_pkg::SRF_REPLY; // [RL6]
  wire go_ok = go_sel != srf_pkg::SRF_RSVD && !bad_sense &&
    !bad_reply && !bad_mix; // [RL17]
  wire idle = state == srf_pkg::SRF_IDLE && !unit_valid_o; // last byte taken
  wire start_ovl = idle && ovl_pend; // [RL10]
  wire start_sw = idle && !ovl_pend && go && go_ok;
  // tag table: entries retire in any order, so answers need not follow
  // the order of the requests
  logic [`SRF_TAGS-1:0] hit, free;
  always_comb begin
    for (int i = 0; i < `SRF_TAGS; i++) begin
      hit[i] = tag_v[i] && tag[i] == wd[15:0];
      free[i] = !tag_v[i];
    end
  end
  wire tag_hit = |hit; // [RL15]
  wire [`SRF_TAGS-1:0] pick = free & (~free + 4'd1);
  // frame length and byte generation
  wire is_rep = f_sel == srf_pkg::SRF_REPLY;
  wire is_sen = f_sel == srf_pkg::SRF_SENSE;
  wire [10:0] flen = `SRF_HDR_LEN + (is_rep ? `SRF_REPLY_LEN : 11'd0) +
    (is_sen ? {1'b0, f_slen} : 11'd0);
  wire [9:0] sidx = 10'(idx - `SRF_B_BLOCK);
  wire [31:0] sword = mem[sidx[9:2]];
  wire [7:0] sbyte = 8'(sword >> {~sidx[1:0], 3'b000});
  logic [7:0] nbyte;
  // unlisted header bytes and block bytes 0-2 fall to zero
  always_comb begin
    nbyte = 8'h00; // [RL20]
    if (idx == `SRF_B_SEL) begin
      nbyte = {6'h00, f_sel}; // [RL19] [RL17]
    end else if (idx == `SRF_B_STATUS) begin
      nbyte = f_stat; // [RL1] [RL3] [RL11]
    end else if (idx == `SRF_B_SLEN_HI) begin
      nbyte = {6'h00, f_slen[9:8]};
    end else if (idx == `SRF_B_SLEN_LO) begin
      nbyte = f_slen[7:0];
    end else if (idx == `SRF_B_RLEN_LO) begin
      nbyte = is_rep ? 8'(`SRF_REPLY_LEN) : 8'h00; // [RL5]
    end else if (is_rep && idx == `SRF_B_CODE) begin
      nbyte = f_code; // [RL7]
    end else if (is_sen && idx >= `SRF_B_BLOCK) begin
      nbyte = sbyte; // [RL13]
    end
  end
  wire load = state == srf_pkg::SRF_SEND && (!unit_valid_o || unit_ready_i);
  wire at_end = idx == flen - 11'd1;
  // frame engine; each unit stands alone, no link or connection state
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state <= srf_pkg::SRF_IDLE;
      idx <= 11'd0;
      o_idx <= 11'd0;
      unit_valid_o <= 1'b0;
      unit_o <= '0;
      f_sel <= srf_pkg::SRF_NONE;
      f_stat <= 8'h00;
      f_code <= 8'h00;
      f_slen <= 10'h000;
      f_task <= 1'b0;
    end else begin
      if (start_ovl) begin
        state <= srf_pkg::SRF_SEND;
        idx <= 11'd0;
        f_sel <= srf_pkg::SRF_REPLY;
        f_stat <= 8'h00;
        f_code <= `SRF_RC_OVERLAP; // [RL10]
        f_slen <= 10'h000;
        f_task <= 1'b0;
      end else if (start_sw) begin
        state <= srf_pkg::SRF_SEND;
        idx <= 11'd0;
        f_sel <= srf_pkg::srf_sel_e'(go_sel);
        f_stat <= go_sel == srf_pkg::SRF_REPLY ? 8'h00 : r_stat; // [RL3]
        f_code <= r_code;
        f_slen <= go_sel == srf_pkg::SRF_SENSE ? r_slen : 10'h000; // [RL1]
        f_task <= go_task;
      end else if (load) begin
        unit_o <= '{data: nbyte, last: at_end}; // [RL16]
        o_idx <= idx;
        idx <= idx + 11'd1;
        if (at_end) begin
          state <= srf_pkg::SRF_IDLE;
        end
      end
      unit_valid_o <= load || (unit_valid_o && !unit_ready_i);
    end
  end
  // pad brings the unit to a whole dword
  assign pad_byte_count_o = 2'(-flen); // [RL14]
  // software registers, flags and tag table; a set beats a clear
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      r_stat <= 8'h00;
      r_code <= 8'h00;
      r_slen <= 10'h000;
      refused <= 1'b0;
      overlap <= 1'b0;
      full <= 1'b0;
      ovl_pend <= 1'b0;
      tag_v <= '0;
    end else begin
      if (do_wr && wa == `SRF_A_STAT_CODE) r_stat <= wd[7:0];
      if (do_wr && wa == `SRF_A_REPLY) r_code <= wd[7:0];
      if (do_wr && wa == `SRF_A_SLEN) r_slen <= wd[9:0];
      refused <= (go && !start_sw) ||
        (refused && !(wr_stat && wd[`SRF_ST_REFUSED]));
      overlap <= (wr_new && tag_hit) ||
        (overlap && !(wr_stat && wd[`SRF_ST_OVERLAP]));
      full <= (wr_new && !tag_hit && free == '0) ||
        (full && !(wr_stat && wd[`SRF_ST_FULL]));
      ovl_pend <= (wr_new && tag_hit) || (ovl_pend && !start_ovl);
      for (int i = 0; i < `SRF_TAGS; i++) begin
        if (wr_done && hit[i]) begin
          tag_v[i] <= 1'b0;
        end
      end
      // lowest free slot takes a new tag; tag words need no reset
      for (int i = 0; i < `SRF_TAGS; i++) begin
        if (wr_new && !tag_hit && pick[i]) begin
          tag_v[i] <= 1'b1;
          tag[i] <= wd[15:0];
        end
      end
    end
  end
  // sense buffer is frozen while a unit streams to keep it coherent
  always_ff @(posedge mclk_i) begin
    if (wr_mem && idle) begin
      mem[wmi] <= (mem[wmi] & ~strb_mask(ws)) | (wd & strb_mask(ws));
    end
  end
  // lite write channel handshakes
  assign s_axi_awready_o = !aw_held;
  assign s_axi_wready_o = !w_held;
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wa <= 12'h000;
      wd <= 32'h0000_0000;
      ws <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= 2'b00;
    end else begin
      if (s_axi_awvalid_i && !aw_held) begin
        aw_held <= 1'b1;
        wa <= {s_axi_awaddr_i[11:2], 2'b00};
      end
      if (s_axi_wvalid_i && !w_held) begin
        w_held <= 1'b1;
        wd <= s_axi_wdata_i;
        ws <= s_axi_wstrb_i;
      end
      if (do_wr) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wa_ok ? 2'b00 : 2'b10;
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end
  // lite read channel; unmapped words answer zero with slverr
  wire [11:0] ra = {s_axi_araddr_i[11:2], 2'b00};
  wire ra_mem = ra >= `SRF_A_MEM_LO && ra <= `SRF_A_MEM_HI;
  wire [31:0] st_word = {28'h0, full, overlap, refused, !idle};
  wire [31:0] rd_mux =
    ra == `SRF_A_CTRL ? {29'h0, f_task, f_sel} :
    ra == `SRF_A_STAT_CODE ? {24'h0, r_stat} :
    ra == `SRF_A_REPLY ? {24'h0, r_code} :
    ra == `SRF_A_SLEN ? {22'h0, r_slen} :
    ra == `SRF_A_STATUS ? st_word :
    ra_mem ? mem[ra[9:2]] : 32'h0000_0000;
  wire ra_ok = ra <= `SRF_A_TAG_DONE || ra_mem;
  assign s_axi_arready_o = !s_axi_rvalid_o;
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= 2'b00;
    end else if (s_axi_arvalid_i && !s_axi_rvalid_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= rd_mux;
      s_axi_rresp_o <= ra_ok ? 2'b00 : 2'b10;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end
  // checks on the emitted unit
  property p_nodata;
    unit_valid_o && f_sel == srf_pkg::SRF_NONE && o_idx >= 11'd16 |->
      unit_o.data == 8'h00 && o_idx < `SRF_B_BLOCK;
  endproperty
  a_nodata: assert property (p_nodata) // [RL1]
    else $error("no-data unit carries nonzero length or a block");
  property p_rep_stat;
    unit_valid_o && is_rep && o_idx == `SRF_B_STATUS |->
      unit_o.data == 8'h00;
  endproperty
  a_rep_stat: assert property (p_rep_stat) // [RL3]
    else $error("reply unit status byte not zero");
  property p_rep_len;
    unit_valid_o && is_rep && o_idx == `SRF_B_RLEN_LO |->
      unit_o.data == 8'h04 && flen == 11'd28;
  endproperty
  a_rep_len: assert property (p_rep_len) // [RL5]
    else $error("reply length not four");
  property p_rep_blk;
    unit_valid_o && is_rep && o_idx >= 11'd24 && o_idx <= 11'd26 |->
      unit_o.data == 8'h00;
  endproperty
  a_rep_blk: assert property (p_rep_blk) // [RL7]
    else $error("reply block reserved byte not zero");
  property p_tm_only;
    $rose(state) && is_rep && !f_task |-> !rc_task_only(f_code);
  endproperty
  a_tm_only: assert property (p_tm_only) // [RL9]
    else $error("task-only reply code sent for a command");
  property p_ovl;
    $fell(ovl_pend) |-> f_code == 8'h0a && is_rep && state;
  endproperty
  a_ovl: assert property (p_ovl) // [RL10]
    else $error("tag overlap not answered with 0a");
  property p_sen_rlen;
    unit_valid_o && is_sen && o_idx >= 11'd20 && o_idx <= 11'd23 |->
      unit_o.data == 8'h00;
  endproperty
  a_sen_rlen: assert property (p_sen_rlen) // [RL11]
    else $error("sense unit reply length not zero");
  property p_sen_len;
    state && is_sen |-> f_slen != 10'h000 && f_slen <= 10'd1000;
  endproperty
  a_sen_len: assert property (p_sen_len) // [RL13]
    else $error("sense length out of range");
  property p_pad;
    state |-> 2'(flen + {9'h0, pad_byte_count_o}) == 2'b00;
  endproperty
  a_pad: assert property (p_pad) // [RL14]
    else $error("pad count does not close the dword");
endmodule

/* srf_sink.sv */
`timescale 1ns/10ps
// initiator side: collects one unit per frame, frame ends on the last flag
module srf_sink (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire srf_pkg::srf_byte_s unit_i,
  input wire logic unit_valid_i,
  input wire logic stall_i,
  output logic unit_ready_o,
  output logic [7:0] buf_o [1024],
  output logic [10:0] len_o,
  output logic [7:0] frames_o
);
  logic [10:0] idx;
  logic phase;
  // stalling drops ready every other cycle to exercise held bytes
  assign unit_ready_o = !stall_i || phase;
  // length comes from the last flag; both length fields are never trusted
  always_ff @(posedge mclk_i) begin
    phase <= srst_i ? 1'b0 : !phase;
    if (srst_i) begin
      idx <= 11'd0;
      frames_o <= 8'd0;
    end else if (unit_valid_i && unit_ready_o) begin
      buf_o[idx] <= unit_i.data;
      idx <= unit_i.last ? 11'd0 : idx + 11'd1;
      // a reserved selector means the frame is thrown away
      if (unit_i.last && buf_o[10][1:0] != 2'b11) begin
        frames_o <= frames_o + 8'd1;
        len_o <= idx + 11'd1;
      end
    end
  end
endmodule

/* tb_top.sv */
`timescale 1ns/10ps
`include "srf_consts.svh"
module tb_top;
  typedef struct {
    logic [1:0] sel;
    logic tsk;
    logic [7:0] code;
    logic [7:0] st;
    logic [10:0] slen;
    logic refused;
  } srf_row_s;
  logic mclk = 0, srst = 1, awv = 0, wv = 0, bready = 0, arv = 0;
  logic rready = 0, stall = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic awready, wready, bvalid, arready, rvalid, unit_valid_o, uready;
  logic [1:0] bresp, rresp, pad;
  srf_pkg::srf_byte_s unit;
  logic [7:0] buf_q [1024];
  logic [10:0] len_q;
  logic [7:0] frames;
  int err_count = 0, n_compared = 0;
  srf_row_s rows [16];
  always #10 mclk = !mclk;
  srf_framer srf_framer_inst (.mclk_i(mclk), .srst_i(srst),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .unit_o(unit),
    .unit_valid_o(unit_valid_o), .unit_ready_i(uready),
    .pad_byte_count_o(pad));
  srf_sink srf_sink_inst (.mclk_i(mclk), .srst_i(srst), .unit_i(unit),
    .unit_valid_i(unit_valid_o), .stall_i(stall), .unit_ready_o(uready),
    .buf_o(buf_q), .len_o(len_q), .frames_o(frames));
  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    chk_val({30'h0, got}, {30'h0, exp});
  endtask
  task automatic hang;
    err_count++;
    test_done();
  endtask
  // write: both channels offered together, each dropped once taken
  task automatic axw(input logic [11:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awv <= 1;
    wv <= 1;
    bready <= 1;
    forever begin
      @(posedge mclk);
      if (awv && awready) awv <= 0;
      if (wv && wready) wv <= 0;
      if (bvalid) break;
      if (++n > 100) hang();
    end
    r = bresp;
    bready <= 0;
    @(posedge mclk); // idle edge: the next call may raise bready again
  endtask
  task automatic axr(input logic [11:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arv <= 1;
    rready <= 1;
    forever begin
      @(posedge mclk);
      if (arv && arready) arv <= 0;
      if (rvalid) break;
      if (++n > 100) hang();
    end
    d = rdata;
    r = rresp;
    rready <= 0;
    @(posedge mclk); // idle edge: the next call may raise rready again
  endtask
  function automatic logic [7:0] sb(input logic [10:0] k);
    return k[7:0] ^ 8'ha5;
  endfunction
  // expected unit byte; everything not named below is reserved zero
  function automatic logic [7:0] exp_b(input logic [10:0] i,
                                       input srf_row_s r);
    if (i == 11'd10) return {6'h0, r.sel};
    if (i == 11'd11) return r.sel == 2'b01 ? 8'h00 : r.st;
    if (r.sel == 2'b10 && i == 11'd18) return {5'h0, r.slen[10:8]};
    if (r.sel == 2'b10 && i == 11'd19) return r.slen[7:0];
    if (r.sel == 2'b01 && i == 11'd23) return 8'h04;
    if (r.sel == 2'b01 && i == 11'd27) return r.code;
    if (r.sel == 2'b10 && i >= 11'd24) return sb(i - 11'd24);
    return 8'h00;
  endfunction
  task automatic run_frame(input srf_row_s r);
    int n;
    logic seen;
    logic [7:0] f0;
    logic [10:0] len;
    f0 = frames;
    n = 0;
    seen = 0;
    len = 11'd24 + (r.sel == 2'b01 ? 11'd4 : 11'd0);
    len = len + (r.sel == 2'b10 ? r.slen : 11'd0);
    while (frames == f0) begin
      @(posedge mclk);
      if (!seen && unit_valid_o === 1'b1) begin
        seen = 1;
        chk_resp(pad, 2'(-len));
      end
      if (++n > 5000) hang();
    end
    chk_val(32'(len_q), 32'(len));
    for (int i = 0; i < len; i++)
      chk_val(32'(buf_q[i]), 32'(exp_b(11'(i), r)));
  endtask
  task automatic launch(input srf_row_s r);
    logic [1:0] b;
    logic [31:0] d;
    logic [7:0] f0;
    f0 = frames;
    axw(`SRF_A_STAT_CODE, {24'h0, r.st}, b);
    axw(`SRF_A_REPLY, {24'h0, r.code}, b);
    axw(`SRF_A_SLEN, {21'h0, r.slen}, b);
    axw(`SRF_A_CTRL, {28'h0, 1'b1, r.tsk, r.sel}, b);
    if (r.refused) begin
      axr(`SRF_A_STATUS, d, b);
      chk_val({31'h0, d[1]}, 32'h1);
      chk_val(32'(frames), 32'(f0));
      axw(`SRF_A_STATUS, 32'he, b);
      axr(`SRF_A_STATUS, d, b);
      chk_val({29'h0, d[3:1]}, 32'h0);
    end else begin
      run_frame(r);
    end
  endtask
  initial begin
    logic [1:0] b;
    logic [31:0] d;
    rows = '{'{0, 0, 0, 8'h02, 0, 0}, '{2, 0, 0, 8'h02, 5, 0},
      '{2, 0, 0, 8'h02, 1000, 0}, '{1, 1, 8'h00, 8'h33, 0, 0},
      '{1, 1, 8'h02, 0, 0, 0}, '{1, 1, 8'h04, 0, 0, 0},
      '{1, 1, 8'h05, 0, 0, 0}, '{1, 1, 8'h08, 0, 0, 0},
      '{1, 1, 8'h09, 0, 0, 0}, '{1, 0, 8'h02, 0, 0, 0},
      '{3, 0, 0, 0, 0, 1}, '{1, 0, 8'h04, 0, 0, 1},
      '{2, 0, 0, 8'h02, 0, 1}, '{2, 0, 0, 8'h02, 1001, 1},
      '{1, 1, 8'h03, 0, 0, 1}, '{0, 1, 0, 0, 0, 1}};
    repeat (20) @(posedge mclk);
    srst <= 0;
    @(posedge mclk);
    // sense pattern loaded once, first byte in the top bits of a word
    for (int w = 0; w < 250; w++)
      axw(12'h400 + 12'(w * 4), {sb(11'(4 * w)), sb(11'(4 * w + 1)),
          sb(11'(4 * w + 2)), sb(11'(4 * w + 3))}, b);
    // table of formats, odd rows with the sink stalling
    for (int i = 0; i < 16; i++) begin
      stall <= i[0];
      launch(rows[i]);
      $display("row %0d done", i);
    end
    // a tag reused while still held gets the overlap code
    axw(`SRF_A_TAG_NEW, 32'h7, b);
    axw(`SRF_A_TAG_NEW, 32'h7, b);
    run_frame('{1, 0, 8'h0a, 0, 0, 0});
    axr(`SRF_A_STATUS, d, b);
    chk_val({31'h0, d[2]}, 32'h1);
    axw(`SRF_A_TAG_DONE, 32'h7, b);
    $display("overlap test done");
    // four slots: the fifth distinct tag finds the table full
    for (int t = 0; t < 5; t++)
      axw(`SRF_A_TAG_NEW, 32'h100 + 32'(t), b);
    axr(`SRF_A_STATUS, d, b);
    chk_val({28'h0, d[3:0]}, 32'hc);
    axw(`SRF_A_STATUS, 32'he, b);
    axr(`SRF_A_STATUS, d, b);
    chk_val(d, 32'h0);
    $display("tag table test done");
    axw(12'h020, 32'h1, b);
    chk_resp(b, 2'b10);
    axr(12'h020, d, b);
    chk_resp(b, 2'b10);
    chk_val(d, 32'h0);
    $display("unmapped test done");
    // reset lands in the middle of a long sense frame
    axw(`SRF_A_SLEN, 32'd1000, b);
    axw(`SRF_A_CTRL, 32'ha, b);
    repeat (6) @(posedge mclk);
    srst <= 1;
    repeat (2) @(posedge mclk);
    chk_val({31'h0, unit_valid_o}, 32'h0);
    chk_resp(pad, 2'b00);
    srst <= 0;
    @(posedge mclk);
    axr(`SRF_A_STATUS, d, b);
    chk_val(d, 32'h0);
    launch(rows[1]);
    $display("reset test done");
    test_done();
  end
endmodule
